/* File: hdl/batmon_pkg.sv */
package batmon_pkg;

    typedef enum logic [1:0] {
        SLOT_BATTERY,
        SLOT_AUX_ZERO,
        SLOT_AUX_ONE
    } vslot_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [2:0]  addr;
        logic [15:0] wdata;
    } host_req_t;

endpackage

/* File: hdl/batmon_regs.svh */
`ifndef BATMON_REGS_SVH
`define BATMON_REGS_SVH

// Clock rate and time figures; cycle counts derive from them
`define CLK_KHZ           25000
`define BUS_LOW_MS        1500
`define BUS_LOW_CYC       (`BUS_LOW_MS * `CLK_KHZ)
`define SLOT_MS           220
`define SLOT_CYC          (`SLOT_MS * `CLK_KHZ)
`define CUR_PERIOD_MS     878
`define CUR_PERIOD_CYC    (`CUR_PERIOD_MS * `CLK_KHZ)
`define PRECHARGE_US      13300
`define PRECHARGE_CYC     ((`PRECHARGE_US * `CLK_KHZ + 999) / 1000)

// Host register indices
`define REG_STATUS        3'h0
`define REG_CURRENT       3'h1
`define REG_ACR           3'h2
`define REG_VOLTAGE       3'h3
`define REG_AUX0          3'h4
`define REG_AUX1          3'h5

// Status/configuration fields
`define CFG_SLEEP_BIT     0
`define CFG_AUXDIS_BIT    1
`define STAT_ASLEEP_BIT   2
`define CFG_SLEEP_RST     1'b0
`define CFG_AUXDIS_RST    1'b0
`define MEAS_RST          16'h0000

`endif

/* File: hdl/battery_monitor_mode_sequencer.sv */
// Behaviour
// - With sleep allowed, both lines low 1.5s to 2.2s puts device asleep.
// - Asleep: no conversions, accumulated charge count changed only by a host write.
// - Active: current measured continuously, kept as signed two-byte value.
// - Every completed current result is added into the charge count unless the host writes the count that cycle.
// - Voltage selector cycles battery, aux zero, aux one in fixed order.
// - Aux divider supply switched off after both aux conversions finish.
// - A control bit keeps the aux divider supply off entirely.
// - Host reads and writes status/config and measurement registers.
// - Either bus line going high returns the device to active mode.
// - Each voltage slot lasts 220ms, a full pass 660ms.
// - Current register updated every 878ms with the interval average.
// - Supply on one precharge time before aux zero, through both slots.
`timescale 1ns/1ps
`include "batmon_regs.svh"

module battery_monitor_mode_sequencer import batmon_pkg::*; #(
    parameter int unsigned SLOT_CYCLES       = `SLOT_CYC,
    parameter int unsigned PRECHARGE_CYCLES  = `PRECHARGE_CYC,
    parameter int unsigned CUR_PERIOD_CYCLES = `CUR_PERIOD_CYC,
    parameter int unsigned BUS_LOW_CYCLES    = `BUS_LOW_CYC
) (
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic               scl_in,
    input  wire logic               sda_in,
    input  wire host_req_t          host_req,
    output logic [15:0]             host_rdata,
    input  wire logic [15:0]        vadc_data,
    input  wire logic signed [15:0] iadc_data,
    output vslot_t                  vadc_sel,
    output logic                    vadc_sample,
    output logic                    iadc_sample,
    output logic                    aux_divider_supply,
    output logic                    asleep
);

    logic [31:0]        slot_cnt_r;
    logic [31:0]        cur_cnt_r;
    logic               slot_end;
    logic               supply_nxt;
    logic               sleep_allow_r;
    logic               aux_supply_disable_r;
    logic signed [15:0] current_r;
    logic [15:0]        acr_r;
    logic [15:0]        volt_r;
    logic [15:0]        aux0_r;
    logic [15:0]        aux1_r;
    logic               wr_status;
    logic               wr_current;
    logic               wr_acr;

    // Clamped accumulate: count sticks at 0 on discharge, at 16'hffff on
    // charge, rather than wrapping and losing the pack state
    function automatic logic [15:0] sat_add(input logic [15:0] acc,
                                            input logic [15:0] delta);
        logic signed [17:0] s;
        s = $signed({2'b00, acc}) + $signed({{2{delta[15]}}, delta});
        if (s < 0)
            sat_add = 16'h0000;
        else if (s > 18'sh0_ffff)
            sat_add = 16'hffff;
        else
            sat_add = s[15:0];
    endfunction

    function automatic logic is_write(input host_req_t r,
                                      input logic [2:0] a);
        is_write = r.wr && r.addr == a;
    endfunction

    assign wr_status  = is_write(host_req, `REG_STATUS);
    assign wr_current = is_write(host_req, `REG_CURRENT);
    assign wr_acr     = is_write(host_req, `REG_ACR);

    bus_wake_timer #(
        .BUS_LOW_CYCLES (BUS_LOW_CYCLES)
    ) u_wake (
        .clk         (clk),
        .srst        (srst),
        .scl_in      (scl_in),
        .sda_in      (sda_in),
        .sleep_allow (sleep_allow_r),
        .asleep      (asleep)
    );

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sleep_allow_r        <= `CFG_SLEEP_RST;
            aux_supply_disable_r <= `CFG_AUXDIS_RST;
        end
        else if (wr_status)
        begin
            sleep_allow_r        <= host_req.wdata[`CFG_SLEEP_BIT];
            aux_supply_disable_r <= host_req.wdata[`CFG_AUXDIS_BIT];
        end
    end

    // Voltage slot sequencer; freezes mid-slot while asleep
    assign slot_end = slot_cnt_r == SLOT_CYCLES - 1;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            slot_cnt_r <= '0;
            vadc_sel   <= SLOT_BATTERY;
        end
        else if (!asleep)
        begin
            if (slot_end)
            begin
                slot_cnt_r <= '0;
                unique case (vadc_sel)
                    SLOT_BATTERY:  vadc_sel <= SLOT_AUX_ZERO;
                    SLOT_AUX_ZERO: vadc_sel <= SLOT_AUX_ONE;
                    SLOT_AUX_ONE:  vadc_sel <= SLOT_BATTERY;
                    default:       vadc_sel <= SLOT_BATTERY;
                endcase
            end
            else
                slot_cnt_r <= slot_cnt_r + 32'd1;
        end
    end

    assign vadc_sample = slot_end && !asleep;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            volt_r <= `MEAS_RST;
            aux0_r <= `MEAS_RST;
            aux1_r <= `MEAS_RST;
        end
        else if (vadc_sample)
        begin
            unique case (vadc_sel)
                SLOT_BATTERY:  volt_r <= vadc_data;
                SLOT_AUX_ZERO: aux0_r <= vadc_data;
                SLOT_AUX_ONE:  aux1_r <= vadc_data;
                default:       volt_r <= volt_r;
            endcase
        end
        else if (host_req.wr)
        begin
            if (host_req.addr == `REG_VOLTAGE)
                volt_r <= host_req.wdata;
            if (host_req.addr == `REG_AUX0)
                aux0_r <= host_req.wdata;
            if (host_req.addr == `REG_AUX1)
                aux1_r <= host_req.wdata;
        end
    end

    // Supply lags the slot state by one register stage, negligible against
    // the precharge time, but keeps the pin glitch free
    always_comb
    begin
        supply_nxt = !aux_supply_disable_r && !asleep
            && (vadc_sel != SLOT_BATTERY
                || slot_cnt_r >= SLOT_CYCLES - PRECHARGE_CYCLES);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            aux_divider_supply <= 1'b0;
        else
            aux_divider_supply <= supply_nxt;
    end

    // Current period timer; the converter integrates over the period, so
    // its output at the tick is already the interval average
    always_ff @(posedge clk)
    begin
        if (srst)
            cur_cnt_r <= '0;
        else if (!asleep)
        begin
            if (cur_cnt_r == CUR_PERIOD_CYCLES - 1)
                cur_cnt_r <= '0;
            else
                cur_cnt_r <= cur_cnt_r + 32'd1;
        end
    end

    assign iadc_sample = !asleep && cur_cnt_r == CUR_PERIOD_CYCLES - 1;

    always_ff @(posedge clk)
    begin
        if (srst)
            current_r <= $signed(`MEAS_RST);
        else if (iadc_sample)
            current_r <= iadc_data;
        else if (wr_current)
            current_r <= $signed(host_req.wdata);
    end

    // A host write to the count wins over an accumulation in the same cycle
    always_ff @(posedge clk)
    begin
        if (srst)
            acr_r <= `MEAS_RST;
        else if (wr_acr)
            acr_r <= host_req.wdata;
        else if (iadc_sample)
            acr_r <= sat_add(acr_r, iadc_data);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            host_rdata <= 16'h0000;
        else if (host_req.rd)
        begin
            unique case (host_req.addr)
                `REG_STATUS:  host_rdata <= {13'h0000, asleep,
                                             aux_supply_disable_r,
                                             sleep_allow_r};
                `REG_CURRENT: host_rdata <= current_r;
                `REG_ACR:     host_rdata <= acr_r;
                `REG_VOLTAGE: host_rdata <= volt_r;
                `REG_AUX0:    host_rdata <= aux0_r;
                `REG_AUX1:    host_rdata <= aux1_r;
                default:      host_rdata <= 16'h0000;
            endcase
        end
    end

    property p_slot_order;
        @(posedge clk) disable iff (srst)
        $changed(vadc_sel) |->
            (vadc_sel == SLOT_AUX_ZERO && $past(vadc_sel) == SLOT_BATTERY)
            || (vadc_sel == SLOT_AUX_ONE && $past(vadc_sel) == SLOT_AUX_ZERO)
            || (vadc_sel == SLOT_BATTERY && $past(vadc_sel) == SLOT_AUX_ONE);
    endproperty
    a_slot_order: assert property (p_slot_order)
        else $error("voltage slot order broken");

    property p_slot_len;
        @(posedge clk) disable iff (srst)
        $changed(vadc_sel) |-> $past(slot_cnt_r) == SLOT_CYCLES - 1;
    endproperty
    a_slot_len: assert property (p_slot_len)
        else $error("voltage slot ended at wrong count");

    property p_supply_disabled;
        @(posedge clk) disable iff (srst)
        aux_supply_disable_r |=> !aux_divider_supply;
    endproperty
    a_supply_disabled: assert property (p_supply_disabled)
        else $error("aux supply on while disabled");

    property p_supply_off_after_aux;
        @(posedge clk) disable iff (srst)
        (vadc_sel == SLOT_AUX_ONE && vadc_sample) |=> ##1 !aux_divider_supply;
    endproperty
    a_supply_off_after_aux: assert property (p_supply_off_after_aux)
        else $error("aux supply still on after aux slots");

    property p_supply_on_aux;
        @(posedge clk) disable iff (srst)
        (vadc_sel == SLOT_BATTERY && !aux_supply_disable_r && !asleep
            && slot_cnt_r == SLOT_CYCLES - PRECHARGE_CYCLES)
            |=> aux_divider_supply;
    endproperty
    a_supply_on_aux: assert property (p_supply_on_aux)
        else $error("aux supply not on at precharge start");

    property p_asleep_quiet;
        @(posedge clk) disable iff (srst)
        asleep && !wr_acr |-> !vadc_sample && !iadc_sample ##1 $stable(acr_r);
    endproperty
    a_asleep_quiet: assert property (p_asleep_quiet)
        else $error("activity or count change while asleep");

    property p_acr_add;
        @(posedge clk) disable iff (srst)
        (iadc_sample && !wr_acr) |=>
            acr_r == sat_add($past(acr_r), $past(iadc_data));
    endproperty
    a_acr_add: assert property (p_acr_add)
        else $error("current result not accumulated");

    property p_current_update;
        @(posedge clk) disable iff (srst)
        iadc_sample |=> current_r == $past(iadc_data)
            ##1 (cur_cnt_r != 32'd0 || asleep);
    endproperty
    a_current_update: assert property (p_current_update)
        else $error("current register not loaded at period end");

    property p_read_acr;
        @(posedge clk) disable iff (srst)
        (host_req.rd && host_req.addr == `REG_ACR) |=>
            host_rdata == $past(acr_r);
    endproperty
    a_read_acr: assert property (p_read_acr)
        else $error("host read of count returned wrong data");

endmodule // battery_monitor_mode_sequencer

/* File: hdl/bus_wake_timer.sv */
`timescale 1ns/1ps
`include "batmon_regs.svh"

module bus_wake_timer #(
    parameter int unsigned BUS_LOW_CYCLES = `BUS_LOW_CYC
) (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic scl_in,
    input  wire logic sda_in,
    input  wire logic sleep_allow,
    output logic      asleep
);

    logic        scl_s1_r;
    logic        scl_s2_r;
    logic        sda_s1_r;
    logic        sda_s2_r;
    logic [31:0] low_cnt_r;
    logic        bus_low;
    logic        timeout;

    always_ff @(posedge clk)
    begin
        scl_s1_r <= scl_in;
        scl_s2_r <= scl_s1_r;
        sda_s1_r <= sda_in;
        sda_s2_r <= sda_s1_r;
    end

    assign bus_low = !scl_s2_r && !sda_s2_r;
    assign timeout = low_cnt_r == BUS_LOW_CYCLES - 1;

    // Restart the count whenever sleep is not allowed, so the bound is
    // measured from the later of line-low and the enable
    always_ff @(posedge clk)
    begin
        if (srst || !bus_low || !sleep_allow || asleep)
            low_cnt_r <= '0;
        else if (!timeout)
            low_cnt_r <= low_cnt_r + 32'd1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            asleep <= 1'b0;
        else if (asleep && !bus_low)
            asleep <= 1'b0;
        else if (!asleep && sleep_allow && bus_low && timeout)
            asleep <= 1'b1;
    end

    property p_sleep_cause;
        @(posedge clk) disable iff (srst)
        $rose(asleep) |-> $past(sleep_allow) && $past(bus_low)
            && $past(low_cnt_r) == BUS_LOW_CYCLES - 1;
    endproperty
    a_sleep_cause: assert property (p_sleep_cause)
        else $error("sleep entered without full bus-low time");

    property p_no_early_sleep;
        @(posedge clk) disable iff (srst)
        (!asleep && low_cnt_r < BUS_LOW_CYCLES - 1) |=> !asleep;
    endproperty
    a_no_early_sleep: assert property (p_no_early_sleep)
        else $error("sleep entered too early");

    property p_wake;
        @(posedge clk) disable iff (srst)
        (asleep && (scl_s2_r || sda_s2_r)) |=> !asleep;
    endproperty
    a_wake: assert property (p_wake)
        else $error("did not wake on released bus line");

endmodule // bus_wake_timer

/* File: verif/battery_monitor_mode_sequencer_tb.sv */
`timescale 1ns/1ps
`include "batmon_regs.svh"

module battery_monitor_mode_sequencer_tb import batmon_pkg::*; ;
    localparam int SLOT  = 40;
    localparam int PRE   = 8;
    localparam int CUR   = 50;
    localparam int BL    = 30;
    localparam int LIMIT = 5000;

    logic               clk;
    logic               srst;
    logic               scl;
    logic               sda;
    host_req_t          host_req;
    logic [15:0]        host_rdata;
    logic [15:0]        vadc_data;
    logic signed [15:0] iadc_data;
    vslot_t             vadc_sel;
    logic               vadc_sample;
    logic               iadc_sample;
    logic               supply;
    logic               asleep;
    int                 cyc;
    int                 n_fail;
    int                 checks;
    int                 last_t[2];
    logic [15:0]        q;

    battery_monitor_mode_sequencer #(
        .SLOT_CYCLES       (SLOT),
        .PRECHARGE_CYCLES  (PRE),
        .CUR_PERIOD_CYCLES (CUR),
        .BUS_LOW_CYCLES    (BL)
    ) battery_monitor_mode_sequencer_inst (
        .clk                (clk),
        .srst               (srst),
        .scl_in             (scl),
        .sda_in             (sda),
        .host_req           (host_req),
        .host_rdata         (host_rdata),
        .vadc_data          (vadc_data),
        .iadc_data          (iadc_data),
        .vadc_sel           (vadc_sel),
        .vadc_sample        (vadc_sample),
        .iadc_sample        (iadc_sample),
        .aux_divider_supply (supply),
        .asleep             (asleep)
    );

    host_model host_model_inst (
        .clk        (clk),
        .host_rdata (host_rdata),
        .host_req   (host_req),
        .scl        (scl),
        .sda        (sda)
    );

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Converter result tagged with the input it came from
    always @(posedge clk)
    begin
        vadc_data <= 16'h0a00 | 16'(vadc_sel);
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            n_fail++;
            report_and_stop();
        end
    end

    task automatic chk_word(input string nm, input logic [15:0] e,
                            input logic [15:0] g);
    begin
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
    begin
        chk_word(nm, 16'(e), 16'(g));
    end
    endtask

    task automatic wait_pulse(input int k, output int gap);
        int n;
    begin
        n = 0;
        @(negedge clk);
        while ((k ? iadc_sample : vadc_sample) !== 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        chk_bit("sample pulse", 1'b1, k ? iadc_sample : vadc_sample);
        gap = cyc - last_t[k];
        last_t[k] = cyc;
    end
    endtask

    task automatic t_reset();
    begin
        chk_bit("supply after reset", 1'b0, supply);
        chk_bit("asleep after reset", 1'b0, asleep);
        for (int i = 0; i < 8; i++)
        begin
            host_model_inst.xfer(1'b0, 3'(i), '0, q);
            chk_word("reset read", 16'h0000, q);
        end
    end
    endtask

    task automatic t_vseq();
        int     g;
        vslot_t prev;
        vslot_t exp_sel;
    begin
        wait_pulse(0, g);
        prev = vadc_sel;
        repeat (6)
        begin
            wait_pulse(0, g);
            chk_word("slot length", 16'(SLOT), 16'(g));
            exp_sel = (prev == SLOT_AUX_ONE) ? SLOT_BATTERY
                                             : vslot_t'(prev + 1);
            chk_word("slot order", 16'(exp_sel), 16'(vadc_sel));
            chk_bit("supply at slot end", 1'b1, supply);
            prev = vadc_sel;
            if (prev == SLOT_AUX_ONE)
            begin
                repeat (2) @(negedge clk);
                chk_bit("supply after aux", 1'b0, supply);
            end
        end
        for (int i = 0; i < 3; i++)
        begin
            host_model_inst.xfer(1'b0, 3'(`REG_VOLTAGE + i), '0, q);
            chk_word("voltage reg", 16'h0a00 + 16'(i), q);
        end
    end
    endtask

    task automatic cur_step(input logic [15:0] iv, input logic [15:0] ea);
        int g;
    begin
        @(posedge clk);
        iadc_data <= iv;
        wait_pulse(1, g);
        chk_word("current period", 16'(CUR), 16'(g));
        host_model_inst.xfer(1'b0, `REG_ACR, '0, q);
        chk_word("charge count", ea, q);
        host_model_inst.xfer(1'b0, `REG_CURRENT, '0, q);
        chk_word("current reg", iv, q);
    end
    endtask

    task automatic t_cur();
        int g;
    begin
        wait_pulse(1, g);
        @(posedge clk);
        iadc_data <= 16'h0020;
        host_model_inst.xfer(1'b1, `REG_ACR, 16'hfff0, q);
        // Walks both clamps: top first, then down onto the zero clamp
        cur_step(16'h0020, 16'hffff);
        cur_step(16'h8000, 16'h7fff);
        cur_step(16'h8000, 16'h0000);
        cur_step(16'h0005, 16'h0005);
    end
    endtask

    task automatic t_auxdis();
        logic on;
    begin
        on = 1'b0;
        host_model_inst.xfer(1'b1, `REG_STATUS, 16'h0002, q);
        // Supply register follows the disable bit one edge later
        @(posedge clk);
        repeat (130)
        begin
            @(negedge clk);
            on = on | supply;
        end
        chk_bit("supply disabled", 1'b0, on);
        host_model_inst.xfer(1'b0, `REG_STATUS, '0, q);
        chk_word("status readback", 16'h0002, q);
        host_model_inst.xfer(1'b1, `REG_STATUS, 16'h0000, q);
    end
    endtask

    task automatic t_sleep();
        int          n;
        logic        any;
        logic [15:0] a0;
    begin
        any = 1'b0;
        host_model_inst.lines(1'b0);
        repeat (3 * BL)
        begin
            @(negedge clk);
            any = any | asleep;
        end
        chk_bit("sleep not allowed", 1'b0, any);
        host_model_inst.lines(1'b1);
        host_model_inst.xfer(1'b1, `REG_STATUS, 16'h0001, q);
        host_model_inst.lines(1'b0);
        n = 0;
        while (asleep !== 1'b1 && n < 3 * BL)
        begin
            @(negedge clk);
            n++;
        end
        chk_bit("sleep delay", 1'b1, 1'(n >= BL && n <= BL + 6));
        host_model_inst.xfer(1'b0, `REG_ACR, '0, a0);
        host_model_inst.xfer(1'b0, `REG_STATUS, '0, q);
        chk_word("status asleep", 16'h0005, q);
        repeat (120)
        begin
            @(negedge clk);
            any = any | vadc_sample | iadc_sample | supply;
        end
        chk_bit("activity asleep", 1'b0, any);
        host_model_inst.xfer(1'b0, `REG_ACR, '0, q);
        chk_word("charge held", a0, q);
        host_model_inst.lines(1'b1);
        n = 0;
        while (asleep !== 1'b0 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        chk_bit("wake delay", 1'b1, 1'(n <= 4));
    end
    endtask

    task automatic report_and_stop();
    begin
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask

    initial
    begin
        srst = 1'b1;
        n_fail = 0;
        checks = 0;
        last_t = '{0, 0};
        iadc_data = '0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        t_reset();
        $display("reset test done");
        t_vseq();
        $display("voltage sequence test done");
        t_cur();
        $display("current test done");
        t_auxdis();
        $display("supply disable test done");
        t_sleep();
        $display("sleep test done");
        report_and_stop();
    end
endmodule // battery_monitor_mode_sequencer_tb

/* File: verif/host_model.sv */
`timescale 1ns/1ps

module host_model import batmon_pkg::*; (
    input  wire logic        clk,
    input  wire logic [15:0] host_rdata,
    output host_req_t        host_req,
    output logic             scl,
    output logic             sda
);
    // Lines left alone sit high through the bus pull-ups
    initial
    begin
        host_req = '0;
        scl      = 1'b1;
        sda      = 1'b1;
    end

    // One decoded word access; read data is taken on the falling edge after the pulse ends
    task automatic xfer(input logic w, input logic [2:0] a,
                        input logic [15:0] d, output logic [15:0] q);
    begin
        @(posedge clk);
        host_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk);
        host_req <= '0;
        @(negedge clk);
        q = host_rdata;
    end
    endtask

    // Both lines driven to the same level; low asks for sleep, also used with sleep not allowed
    task automatic lines(input logic lvl);
    begin
        @(posedge clk);
        scl <= lvl;
        sda <= lvl;
    end
    endtask
endmodule // host_model
